// [rtl/sac_top.sv]
// Converter control: APB registers, shared port pins, prescaler and SAR sequencing
`timescale 1ns/10ps
`include "sac_cfg.svh"

// How it works
// - A status/control write starts a conversion taking 16 to 17 converter clocks
// - At completion load result, then set done flag or raise interrupt per enable
// - Select field routes one of four shared port pins to the converter
// - Selected pin is forced to converter input; port writes do not reach it
// - Unselected pins stay ordinary general-purpose port pins
// - Port read of selected pin gives 0 if direction 0, else data latch
// - Eight-bit result; full scale all ones, ground zeros, out-of-range clamped
// - Continuous mode overwrites the data register with every new result
// - Continuous mode restarts after each conversion until software clears the bit
// - Continuous mode sets done flag after first result until write or data read
// - With interrupt enabled: flag 0 gives CPU interrupt, flag 1 gives DMA request
// - With interrupt enabled the done flag is not used to mark completion
// - Conversions continue in wait mode; the interrupt can wake the processor
// - Stop entry aborts conversion; conversions resume when stop ends
// - Five-bit select field; all ones powers off; reset sets all ones
// - Pending interrupt clears on data register read or status/control write
// - Continuous clear gives one conversion per start; reset clears control bits
// - Converter clock is source divided by 1 to 16; reset selects oscillator
module sac_top (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        oscillator_output_clock,
    input  wire logic        stop_mode,
    input  wire logic        comparator_in,
    output logic      [7:0]  dac_code,
    output logic      [4:0]  input_select_field,
    output logic             converter_power_on,
    output logic             cpu_irq,
    output logic             dma_req,
    input  wire logic [3:0]  shared_port_pins_in,
    output logic      [3:0]  shared_port_pins_out,
    output logic      [3:0]  shared_port_pins_oe_n
);

    sac_pkg::sac_ctrl_s  ctrl_reg;
    sac_pkg::sac_clk_s   clk_reg;
    sac_pkg::sac_state_e state_reg;
    logic [7:0]  data_reg;
    logic [3:0]  port_data_reg;
    logic [3:0]  port_dir_reg;
    logic [3:0]  tick_cnt_reg;
    logic [7:0]  sar_reg;
    logic        resume_reg;
    logic        sample_reg;
    logic [31:0] prdata_reg;
    logic        pready_reg;
    logic        pslverr_reg;
    logic        power_reg;
    logic        cpu_irq_reg;
    logic        dma_req_reg;
    logic [3:0]  pin_out_reg;
    logic [3:0]  pin_oe_n_reg;
    logic [5:0]  sync1_reg;
    logic [5:0]  sync2_reg;
    logic        osc_prev_reg;

    logic        setup;
    logic        access;
    logic        wr_ctrl;
    logic        rd_data;
    logic        addr_hit;
    logic [7:0]  rd_mux;
    logic [3:0]  in_use;
    logic [3:0]  port_rd;
    logic        src_tick;
    logic        conv_tick;
    logic        start;
    logic        conv_done;
    logic        power_next;
    logic [2:0]  bit_idx;
    logic [7:0]  bit_mask;
    logic [7:0]  sar_dec;

    // ----------------------------------------------------------------
    // Input synchronisers
    // ----------------------------------------------------------------
    // Bits 3:0 port pins, 4 comparator, 5 oscillator clock
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sync1_reg    <= 6'h00;
            sync2_reg    <= 6'h00;
            osc_prev_reg <= 1'b0;
        end
        else
        begin
            sync1_reg    <= {oscillator_output_clock, comparator_in, shared_port_pins_in};
            sync2_reg    <= sync1_reg;
            osc_prev_reg <= sync2_reg[5];
        end
    end

    // Bus clock source ticks every cycle; oscillator ticks on its rising edge
    assign src_tick = clk_reg.converter_clock_source ? 1'b1 : (sync2_reg[5] && !osc_prev_reg);

    sac_clkdiv #(
        .DIV_W (3),
        .CNT_W (4)
    ) u_div (
        .clk       (clk),
        .rst       (rst),
        .src_tick  (src_tick),
        .div_sel   (clk_reg.converter_clock_divider),
        .conv_tick (conv_tick)
    );

    // ----------------------------------------------------------------
    // APB slave
    // ----------------------------------------------------------------
    assign setup   = psel && !penable;
    assign access  = psel && penable && pready_reg;
    assign wr_ctrl = access && pwrite && (paddr == `SAC_OFF_CTRL);
    assign rd_data = access && !pwrite && (paddr == `SAC_OFF_DATA);

    always_comb
    begin
        for (int i = 0; i < `SAC_CHANNELS; i++)
        begin
            in_use[i]  = (ctrl_reg.input_select_field == 5'(i));
            port_rd[i] = port_dir_reg[i] ? port_data_reg[i]
                       : (in_use[i] ? 1'b0 : sync2_reg[i]);
        end
    end

    always_comb
    begin
        addr_hit = 1'b1;
        rd_mux   = 8'h00;
        case (paddr)
            `SAC_OFF_CTRL: rd_mux = ctrl_reg;
            `SAC_OFF_DATA: rd_mux = data_reg;
            `SAC_OFF_CLK:  rd_mux = clk_reg;
            `SAC_OFF_PDAT: rd_mux = {4'h0, port_rd};
            `SAC_OFF_PDIR: rd_mux = {4'h0, port_dir_reg};
            default:       addr_hit = 1'b0;
        endcase
    end

    // Answer is registered in the setup cycle, so access needs no wait state
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pready_reg  <= setup;
            prdata_reg  <= (setup && !pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
            pslverr_reg <= setup && !addr_hit;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            clk_reg       <= `SAC_CLK_RESET;
            port_data_reg <= 4'h0;
            port_dir_reg  <= 4'h0;
        end
        else if (access && pwrite)
        begin
            if (paddr == `SAC_OFF_CLK)
                clk_reg <= {pwdata[7:4], 4'h0};
            if (paddr == `SAC_OFF_PDAT)
                port_data_reg <= pwdata[3:0];
            if (paddr == `SAC_OFF_PDIR)
                port_dir_reg <= pwdata[3:0];
        end
    end

    // ----------------------------------------------------------------
    // Status/control register and completion events
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ctrl_reg <= `SAC_CTRL_RESET;
        else if (wr_ctrl)
        begin
            ctrl_reg.input_select_field    <= pwdata[4:0];
            ctrl_reg.continuous_convert    <= pwdata[5];
            ctrl_reg.conversion_irq_enable <= pwdata[6];
            // Flag can be written to 1 only when the same write enables interrupts; otherwise the write clears it
            ctrl_reg.conversion_done_flag  <= pwdata[7] && pwdata[6];
        end
        else if (conv_done && !ctrl_reg.conversion_irq_enable)
            ctrl_reg.conversion_done_flag <= 1'b1;
        else if (rd_data)
            ctrl_reg.conversion_done_flag <= 1'b0;
    end

    // Not gated by anything low-power: the request must wake a waiting CPU
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            cpu_irq_reg <= 1'b0;
            dma_req_reg <= 1'b0;
        end
        else if (conv_done && ctrl_reg.conversion_irq_enable)
        begin
            cpu_irq_reg <= cpu_irq_reg || !ctrl_reg.conversion_done_flag;
            dma_req_reg <= dma_req_reg || ctrl_reg.conversion_done_flag;
        end
        else if (wr_ctrl || rd_data)
        begin
            cpu_irq_reg <= 1'b0;
            dma_req_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            data_reg <= 8'h00;
        else if (conv_done)
            data_reg <= sar_dec;
    end

    // ----------------------------------------------------------------
    // Conversion sequencer
    // ----------------------------------------------------------------
    // Even ticks place a trial bit, odd ticks keep or drop it: 8 bits in 16 ticks
    assign bit_idx    = `SAC_MSB_INDEX - tick_cnt_reg[3:1];
    assign bit_mask   = 8'h01 << bit_idx;
    assign sar_dec    = sync2_reg[4] ? sar_reg : (sar_reg & ~bit_mask);
    assign power_next = wr_ctrl ? (pwdata[4:0] != `SAC_SEL_OFF)
                                : (ctrl_reg.input_select_field != `SAC_SEL_OFF);
    assign start      = !stop_mode && power_next && (wr_ctrl || resume_reg);
    assign conv_done  = (state_reg == sac_pkg::SAC_CONVERT) && conv_tick && !stop_mode
                        && !wr_ctrl && (tick_cnt_reg == `SAC_LAST_TICK);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg    <= sac_pkg::SAC_IDLE;
            tick_cnt_reg <= 4'h0;
            sar_reg      <= 8'h00;
            resume_reg   <= 1'b0;
            sample_reg   <= 1'b0;
        end
        else if (stop_mode)
        begin
            state_reg  <= sac_pkg::SAC_IDLE;
            resume_reg <= resume_reg || (state_reg == sac_pkg::SAC_CONVERT);
        end
        else if (start)
        begin
            state_reg    <= sac_pkg::SAC_CONVERT;
            tick_cnt_reg <= 4'h0;
            sar_reg      <= 8'h00;
            resume_reg   <= 1'b0;
            sample_reg   <= 1'b1;
        end
        else if (wr_ctrl || !power_next)
        begin
            state_reg  <= sac_pkg::SAC_IDLE;
            resume_reg <= 1'b0;
        end
        else
        begin
            case (state_reg)
                sac_pkg::SAC_IDLE:
                    tick_cnt_reg <= 4'h0;
                sac_pkg::SAC_CONVERT:
                    if (conv_done)
                    begin
                        tick_cnt_reg <= 4'h0;
                        sar_reg      <= 8'h00;
                        sample_reg   <= 1'b1;
                        if (!ctrl_reg.continuous_convert)
                            state_reg <= sac_pkg::SAC_IDLE;
                    end
                    // First tick only samples, so a conversion spans 16 to 17 ticks
                    else if (conv_tick && sample_reg)
                        sample_reg <= 1'b0;
                    else if (conv_tick)
                    begin
                        tick_cnt_reg <= tick_cnt_reg + 4'h1;
                        sar_reg      <= tick_cnt_reg[0] ? sar_dec : (sar_reg | bit_mask);
                    end
                default:
                    state_reg <= sac_pkg::SAC_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Pin and analog outputs
    // ----------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin_out_reg  <= 4'h0;
            pin_oe_n_reg <= 4'hf;
            power_reg    <= 1'b0;
        end
        else
        begin
            pin_out_reg  <= port_data_reg;
            pin_oe_n_reg <= ~(port_dir_reg & ~in_use);
            power_reg    <= !stop_mode && (ctrl_reg.input_select_field != `SAC_SEL_OFF);
        end
    end

    assign prdata                = prdata_reg;
    assign pready                = pready_reg;
    assign pslverr               = pslverr_reg;
    assign dac_code              = sar_reg;
    assign input_select_field    = ctrl_reg.input_select_field;
    assign converter_power_on    = power_reg;
    assign cpu_irq               = cpu_irq_reg;
    assign dma_req               = dma_req_reg;
    assign shared_port_pins_out  = pin_out_reg;
    assign shared_port_pins_oe_n = pin_oe_n_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    logic [4:0] ticks_seen_reg;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            ticks_seen_reg <= 5'h00;
        else if (start || conv_done)
            ticks_seen_reg <= 5'h00;
        else if (conv_tick && (state_reg == sac_pkg::SAC_CONVERT) && (ticks_seen_reg != 5'h1f))
            ticks_seen_reg <= ticks_seen_reg + 5'h01;
    end

    sequence apb_setup_s;
        psel && !penable;
    endsequence

    sequence done_enabled_s;
        conv_done && ctrl_reg.conversion_irq_enable;
    endsequence

    apb_ready_a: assert property (@(posedge clk) disable iff (rst)
        apb_setup_s |=> pready ##1 !pready)
        else $error("pready not raised one cycle after setup");

    conv_length_a: assert property (@(posedge clk) disable iff (rst)
        conv_done |-> (ticks_seen_reg == `SAC_CONV_TICKS))
        else $error("conversion did not take 16 converter clocks");

    result_load_a: assert property (@(posedge clk) disable iff (rst)
        conv_done |=> (data_reg == $past(sar_dec)) && (state_reg != $past(state_reg)
        || $past(ctrl_reg.continuous_convert)))
        else $error("result not loaded at completion");

    flag_set_a: assert property (@(posedge clk) disable iff (rst)
        conv_done && !ctrl_reg.conversion_irq_enable |=> ctrl_reg.conversion_done_flag
        ##1 (ctrl_reg.conversion_done_flag || $past(rd_data) || $past(wr_ctrl)))
        else $error("done flag not set or lost without a clear");

    irq_raise_a: assert property (@(posedge clk) disable iff (rst)
        done_enabled_s ##0 !ctrl_reg.conversion_done_flag |=> cpu_irq && !ctrl_reg.conversion_done_flag)
        else $error("cpu interrupt not raised or flag used with interrupts");

    dma_path_a: assert property (@(posedge clk) disable iff (rst)
        done_enabled_s ##0 ctrl_reg.conversion_done_flag |=> dma_req && ($stable(cpu_irq)))
        else $error("dma request not raised when flag set");

    irq_clear_a: assert property (@(posedge clk) disable iff (rst)
        (rd_data || wr_ctrl) && !conv_done |=> !cpu_irq && !dma_req)
        else $error("pending interrupt not cleared");

    pin_forced_a: assert property (@(posedge clk) disable iff (rst)
        (ctrl_reg.input_select_field < 5'h04)
        |=> shared_port_pins_oe_n[$past(ctrl_reg.input_select_field[1:0])] == 1'b1)
        else $error("selected pin still driven by the port");

    stop_abort_a: assert property (@(posedge clk) disable iff (rst)
        stop_mode |-> !conv_done ##1 (state_reg == sac_pkg::SAC_IDLE))
        else $error("conversion not aborted on stop");

    power_off_a: assert property (@(posedge clk) disable iff (rst)
        (ctrl_reg.input_select_field == `SAC_SEL_OFF) |-> (state_reg == sac_pkg::SAC_IDLE)
        ##1 !converter_power_on)
        else $error("converter active while powered off");

    single_shot_a: assert property (@(posedge clk) disable iff (rst)
        conv_done && !stop_mode |=> (state_reg == sac_pkg::SAC_CONVERT)
        == $past(ctrl_reg.continuous_convert))
        else $error("continuous setting not obeyed after completion");

endmodule

// [rtl/sac_cfg.svh]
// Register map, reset values and conversion timing of the converter control block
`ifndef SAC_CFG_SVH
`define SAC_CFG_SVH

`define SAC_OFF_CTRL    8'h3c
`define SAC_OFF_DATA    8'h40
`define SAC_OFF_CLK     8'h44
`define SAC_OFF_PDAT    8'h48
`define SAC_OFF_PDIR    8'h4c

`define SAC_CTRL_RESET  8'h1f
`define SAC_CLK_RESET   8'h00
`define SAC_SEL_OFF     5'h1f
`define SAC_CHANNELS    4
`define SAC_CONV_TICKS  5'h10
`define SAC_LAST_TICK   4'hf
`define SAC_MSB_INDEX   3'h7

`endif

// [rtl/sac_pkg.sv]
// Types shared by the converter control block
package sac_pkg;

    typedef enum logic {
        SAC_IDLE,
        SAC_CONVERT
    } sac_state_e;

    // Status/control register layout
    typedef struct packed {
        logic       conversion_done_flag;
        logic       conversion_irq_enable;
        logic       continuous_convert;
        logic [4:0] input_select_field;
    } sac_ctrl_s;

    // Converter clock register layout
    typedef struct packed {
        logic [2:0] converter_clock_divider;
        logic       converter_clock_source;
        logic [3:0] reserved;
    } sac_clk_s;

endpackage

// [rtl/sac_clkdiv.sv]
// Converter clock prescaler: turns source ticks into converter clock enables
`timescale 1ns/10ps

module sac_clkdiv #(
    parameter int DIV_W = 3,
    parameter int CNT_W = 4
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             src_tick,
    input  wire logic [DIV_W-1:0] div_sel,
    output logic                  conv_tick
);

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] mask;

    // Divide by 1, 2, 4, 8; any code with the top bit set divides by 16
    always_comb
    begin
        case (div_sel)
            3'h0:    mask = 4'h0;
            3'h1:    mask = 4'h1;
            3'h2:    mask = 4'h3;
            3'h3:    mask = 4'h7;
            default: mask = 4'hf;
        endcase
    end

    // Free running so a start lands anywhere in the period
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            cnt_reg <= 4'h0;
        else if (src_tick)
            cnt_reg <= cnt_reg + 4'h1;
    end

    assign conv_tick = src_tick && ((cnt_reg & mask) == mask);

endmodule

// [tb/sac_analog_model.sv]
// Behavioural analog mux and comparator facing the converter control block
`timescale 1ns/10ps

module sac_analog_model (
    input  wire logic        clk,
    input  wire logic [7:0]  dac_code,
    input  wire logic [4:0]  input_select_field,
    input  wire logic        converter_power_on,
    input  wire logic [39:0] chan_level,
    output logic             comparator_in
);
    // ----------------------------------------
    // Level at the comparator
    // ----------------------------------------
    // Ten bits per level so inputs above the high reference can be modelled
    logic [9:0] vin;
    logic       junk = 1'b0;

    always_comb
    begin
        case (input_select_field)
            5'h00, 5'h01, 5'h02, 5'h03: vin = chan_level[input_select_field[1:0]*10 +: 10];
            5'h1d:   vin = 10'h0ff;
            5'h1e:   vin = 10'h000;
            default: vin = {9'h000, junk};
        endcase
    end

    // Unpowered core answers with a toggling level, never a steady one
    always_ff @(posedge clk)
    begin
        junk          <= ~junk;
        comparator_in <= converter_power_on ? ({2'h0, dac_code} <= vin) : junk;
    end
endmodule

// [tb/test_sar_adc_control.sv]
// Self-checking bench for the converter control block
`timescale 1ns/10ps
`include "sac_cfg.svh"

module test_sar_adc_control;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic        clk, rst, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        osc_clk, stop_mode, comparator_in, converter_power_on;
    logic        cpu_irq, dma_req, err;
    logic [7:0]  dac_code;
    logic [4:0]  input_select_field;
    logic [3:0]  pins_out, pins_oe_n, pins_ext, pins_wire;
    logic [39:0] chan_level;
    logic [31:0] rd;
    int          num_errors, n_tests, cyc;
    logic [4:0]  sel_tab [6];
    logic [7:0]  res_tab [6];

    assign pins_wire = (pins_out & ~pins_oe_n) | (pins_ext & pins_oe_n);

    sac_top u_sac_top (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .oscillator_output_clock(osc_clk),
        .stop_mode(stop_mode), .comparator_in(comparator_in), .dac_code(dac_code),
        .input_select_field(input_select_field), .converter_power_on(converter_power_on),
        .cpu_irq(cpu_irq), .dma_req(dma_req), .shared_port_pins_in(pins_wire),
        .shared_port_pins_out(pins_out), .shared_port_pins_oe_n(pins_oe_n));

    sac_analog_model u_sac_analog_model (.clk(clk), .dac_code(dac_code),
        .input_select_field(input_select_field), .converter_power_on(converter_power_on),
        .chan_level(chan_level), .comparator_in(comparator_in));

    // ----------------------------------------
    // Clocks and watchdog
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // Source tick every five bus clocks, leaving the comparator time to settle
    initial
    begin
        osc_clk = 1'b0;
        #3;
        forever #20 osc_clk = ~osc_clk;
    end

    initial
    begin
        #400000;
        num_errors++;
        $display("BAD t=%0t watchdog expired", $time);
        tally_and_finish();
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        chk({31'h0, pready}, 32'h1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wait_done();
        int k;
        k = 0;
        do
        begin
            apb(1'b0, `SAC_OFF_CTRL, 32'h0);
            k++;
        end
        while (rd[7] !== 1'b1 && k < 500);
        chk({31'h0, rd[7]}, 32'h1);
    endtask

    task automatic wait_evt(input logic dma, output int n);
        n = 0;
        while ((dma ? dma_req : cpu_irq) !== 1'b1 && n < 3000)
        begin
            @(posedge clk);
            n++;
        end
        chk({31'h0, (dma ? dma_req : cpu_irq)}, 32'h1);
    endtask

    task automatic tally_and_finish();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
        begin
            $display("Run complete: PASS");
        end
        else
        begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Tests
    // ----------------------------------------
    initial
    begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        stop_mode = 1'b0;
        pins_ext = 4'hf;
        num_errors = 0;
        n_tests = 0;
        chan_level = {10'h3ff, 10'h0c3, 10'h05a, 10'h011};
        sel_tab = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h1d, 5'h1e};
        res_tab = '{8'h11, 8'h5a, 8'hc3, 8'hff, 8'hff, 8'h00};
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        chk(input_select_field, 32'h1f);
        chk(dac_code, 32'h0);
        apb(1'b0, `SAC_OFF_CTRL, 32'h0);
        chk(rd, 32'h1f);
        apb(1'b0, `SAC_OFF_CLK, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 8'h50, 32'h0);
        chk({31'h0, err}, 32'h1);
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, `SAC_OFF_CTRL, {27'h0, sel_tab[i]});
            wait_done();
            chk(rd, {24'h0, 3'h4, sel_tab[i]});
            apb(1'b0, `SAC_OFF_DATA, 32'h0);
            chk(rd, {24'h0, res_tab[i]});
        end
        repeat (200) @(posedge clk);
        apb(1'b0, `SAC_OFF_CTRL, 32'h0);
        chk(rd, 32'h1e);
        // Interrupt path, conversion time and flag behaviour
        apb(1'b1, `SAC_OFF_CTRL, 32'h41);
        wait_evt(1'b0, cyc);
        chk(32'(cyc >= 75 && cyc <= 93), 32'h1);
        chk({31'h0, converter_power_on}, 32'h1);
        chk({31'h0, dma_req}, 32'h0);
        apb(1'b0, `SAC_OFF_CTRL, 32'h0);
        chk(rd, 32'h41);
        apb(1'b0, `SAC_OFF_DATA, 32'h0);
        chk(rd, 32'h5a);
        @(negedge clk);
        chk({31'h0, cpu_irq}, 32'h0);
        apb(1'b1, `SAC_OFF_CTRL, 32'hc1);
        wait_evt(1'b1, cyc);
        chk({31'h0, cpu_irq}, 32'h0);
        apb(1'b1, `SAC_OFF_CTRL, 32'h1f);
        @(negedge clk);
        chk({31'h0, dma_req}, 32'h0);
        @(negedge clk);
        chk({31'h0, converter_power_on}, 32'h0);
        // Divide by two doubles the conversion time
        apb(1'b1, `SAC_OFF_CLK, 32'h20);
        apb(1'b1, `SAC_OFF_CTRL, 32'h42);
        wait_evt(1'b0, cyc);
        chk(32'(cyc >= 150 && cyc <= 178), 32'h1);
        apb(1'b1, `SAC_OFF_CLK, 32'h0);
        apb(1'b0, `SAC_OFF_DATA, 32'h0);
        chk(rd, 32'hc3);
        // Bus clock source, divide by four and by sixteen
        apb(1'b1, `SAC_OFF_CLK, 32'h50);
        apb(1'b1, `SAC_OFF_CTRL, 32'h43);
        wait_evt(1'b0, cyc);
        chk(32'(cyc >= 64 && cyc <= 70), 32'h1);
        apb(1'b0, `SAC_OFF_DATA, 32'h0);
        chk(rd, 32'hff);
        apb(1'b1, `SAC_OFF_CLK, 32'h90);
        apb(1'b1, `SAC_OFF_CTRL, 32'h43);
        wait_evt(1'b0, cyc);
        chk(32'(cyc >= 256 && cyc <= 274), 32'h1);
        apb(1'b1, `SAC_OFF_CLK, 32'h0);
        apb(1'b0, `SAC_OFF_DATA, 32'h0);
        chk(rd, 32'hff);
        // Continuous mode with a moving input
        apb(1'b1, `SAC_OFF_CTRL, 32'h22);
        wait_done();
        chk({31'h0, rd[7]}, 32'h1);
        chan_level[29:20] <= 10'h040;
        repeat (250) @(posedge clk);
        apb(1'b0, `SAC_OFF_CTRL, 32'h0);
        chk(rd, 32'ha2);
        apb(1'b0, `SAC_OFF_DATA, 32'h0);
        chk(rd, 32'h40);
        apb(1'b1, `SAC_OFF_CTRL, 32'h1f);
        // Stop entry in mid conversion, then resume
        apb(1'b1, `SAC_OFF_CTRL, 32'h01);
        repeat (30) @(posedge clk);
        stop_mode <= 1'b1;
        repeat (200) @(posedge clk);
        chk({31'h0, converter_power_on}, 32'h0);
        apb(1'b0, `SAC_OFF_CTRL, 32'h0);
        chk(rd, 32'h01);
        apb(1'b0, `SAC_OFF_DATA, 32'h0);
        chk(rd, 32'h40);
        stop_mode <= 1'b0;
        wait_done();
        chk(rd, 32'h81);
        apb(1'b0, `SAC_OFF_DATA, 32'h0);
        chk(rd, 32'h5a);
        // Shared pins with input one selected
        apb(1'b1, `SAC_OFF_PDIR, 32'h0f);
        apb(1'b1, `SAC_OFF_PDAT, 32'h08);
        repeat (2) @(negedge clk);
        chk(pins_oe_n, 32'h2);
        chk(pins_wire, 32'ha);
        apb(1'b0, `SAC_OFF_PDAT, 32'h0);
        chk(rd, 32'h08);
        pins_ext <= 4'he;
        apb(1'b1, `SAC_OFF_PDIR, 32'h00);
        repeat (4) @(posedge clk);
        apb(1'b0, `SAC_OFF_PDAT, 32'h0);
        chk(rd, 32'h0c);
        chk(pins_oe_n, 32'hf);
        tally_and_finish();
    end
endmodule
